/* common/ssl_pkg.sv */
// shared constants and types for the synthesizer serial load port
package ssl_pkg;
	localparam int SSL_WORD_W      = 24;
	localparam int SSL_SEL_W       = 2;
	localparam int SSL_SEL_MSB     = 1;
	localparam int SSL_SEL_LSB     = 0;
	localparam int SSL_NUM_LATCH   = 4;
	localparam int SSL_LATCH_CTRL  = 3;
	localparam int SSL_SWPD_BIT    = 2;
	localparam int SSL_MON_MSB     = 5;
	localparam int SSL_MON_LSB     = 3;
	localparam logic [23:0] SSL_LATCH_RST = 24'h00_0000;
	localparam logic [2:0] SSL_MON_HIZ   = 3'h0;
	localparam logic [2:0] SSL_MON_DLD   = 3'h1;
	localparam logic [2:0] SSL_MON_ALD   = 3'h2;
	localparam logic [2:0] SSL_MON_NDIV  = 3'h3;
	localparam logic [2:0] SSL_MON_RDIV  = 3'h4;

	typedef struct packed {
		logic dig_lock;
		logic ana_lock;
		logic n_div;
		logic r_div;
	} ssl_mon_src_t;

	typedef struct packed {
		logic chip_en;
		logic sw_pd;
	} ssl_pwr_t;
endpackage

/* src/ssl_load_port.sv */
// serial configuration load port with power and monitor control
`timescale 1ns/1ps
// Behaviour
// [RL1] chip enable low forces power-down whatever the software power-down bit says
// [RL2] charge pump on only with chip enable high and software power-down clear
// [RL3] a 24-bit shift register takes one data bit per serial clock
// [RL4] data is sampled on each rising serial clock edge
// [RL5] words arrive MSB first and shift toward the register's high end
// [RL6] load strobe rising copies the shift register into the selected latch
// [RL7] monitor output selects digital or analog lock, divided RF or divided reference
// [RL8] monitor output can be set to high impedance
// [RL9] latch select comes from word bits; latches hold until a load
module ssl_load_port
	import ssl_pkg::*;
#(
	parameter int WORD_W = SSL_WORD_W
) (
	// system
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	// serial link
	input  wire logic                    ser_clk,
	input  wire logic                    ser_data,
	input  wire logic                    load_strobe,
	// power pin
	input  wire logic                    chip_en,
	// monitor sources
	input  wire ssl_mon_src_t            mon_src,
	// outputs
	output logic                         monitor_output_o,
	output logic                         monitor_output_oe_n,
	output logic                         power_down,
	output logic                         cp_enable,
	output logic [SSL_NUM_LATCH*WORD_W-1:0] latch_words
);
	logic                 rst_s1_r, rst_n_r;
	logic [WORD_W-1:0]    shift_r;
	logic [WORD_W-1:0]    held_r;
	logic                 held_tgl_r;
	logic [2:0]           tgl_sync_r;
	logic [1:0]           ce_sync_r;
	ssl_mon_src_t         src_s1_r, src_s2_r;
	logic [WORD_W-1:0]    latch_r [SSL_NUM_LATCH];
	logic [WORD_W-1:0]    ctrl_w;
	logic                 mon_nxt;

	// reset release through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// shift on link clock; link clock may stop between words
	always_ff @(posedge ser_clk) begin
		shift_r <= {shift_r[WORD_W-2:0], ser_data}; // see [RL3] see [RL4] see [RL5]
	end

	// strobe edge captures word asynchronously to clk; shift clock idle then
	always_ff @(posedge load_strobe or negedge arst_n) begin
		if (!arst_n) begin
			held_r     <= '0;
			held_tgl_r <= 1'b0;
		end else begin
			held_r     <= shift_r; // see [RL6]
			held_tgl_r <= ~held_tgl_r;
		end
	end

	// toggle crossing into clk; held word is stable once toggle seen
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			tgl_sync_r <= '0;
		end else begin
			tgl_sync_r <= {tgl_sync_r[1:0], held_tgl_r};
		end
	end

	// one latch per select code
	generate
		for (genvar i = 0; i < SSL_NUM_LATCH; i++) begin : g_latch
			always_ff @(posedge clk or negedge rst_n_r) begin
				if (!rst_n_r) begin
					latch_r[i] <= SSL_LATCH_RST;
				end else if ((tgl_sync_r[2] != tgl_sync_r[1]) &&
					(held_r[SSL_SEL_MSB:SSL_SEL_LSB] == SSL_SEL_W'(i))) begin
					latch_r[i] <= held_r; // see [RL6] see [RL9]
				end
			end
			assign latch_words[i*WORD_W +: WORD_W] = latch_r[i];
		end
	endgenerate

	assign ctrl_w = latch_r[SSL_LATCH_CTRL];

	// pin and source synchronisers
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ce_sync_r <= '0;
			src_s1_r  <= '0;
			src_s2_r  <= '0;
		end else begin
			ce_sync_r <= {ce_sync_r[0], chip_en};
			src_s1_r  <= mon_src;
			src_s2_r  <= src_s1_r;
		end
	end

	// power control; reset leaves the part powered down
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			power_down <= 1'b1;
			cp_enable  <= 1'b0;
		end else begin
			power_down <= !ce_sync_r[1] || ctrl_w[SSL_SWPD_BIT]; // see [RL1]
			cp_enable  <= ce_sync_r[1] && !ctrl_w[SSL_SWPD_BIT]; // see [RL2]
		end
	end

	// monitor mux
	always_comb begin
		mon_nxt = 1'b0;
		case (ctrl_w[SSL_MON_MSB:SSL_MON_LSB])
			SSL_MON_DLD:  mon_nxt = src_s2_r.dig_lock; // see [RL7]
			SSL_MON_ALD:  mon_nxt = src_s2_r.ana_lock;
			SSL_MON_NDIV: mon_nxt = src_s2_r.n_div;
			SSL_MON_RDIV: mon_nxt = src_s2_r.r_div;
			default:      mon_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			monitor_output_o    <= 1'b0;
			monitor_output_oe_n <= 1'b1;
		end else begin
			monitor_output_o    <= mon_nxt;
			// unknown codes also float the pin
			monitor_output_oe_n <= !(ctrl_w[SSL_MON_MSB:SSL_MON_LSB] inside
				{SSL_MON_DLD, SSL_MON_ALD, SSL_MON_NDIV, SSL_MON_RDIV}); // see [RL8]
		end
	end
endmodule

/* test/ssl_load_port_checker.sv */
// assertions for the serial load port
`timescale 1ns/1ps
module ssl_load_port_checker
	import ssl_pkg::*;
#(parameter int WORD_W = 24) (
	input wire logic clk, arst_n, ser_clk, ser_data, load_strobe, chip_en,
	input wire ssl_mon_src_t mon_src,
	input wire logic monitor_output_o, monitor_output_oe_n, power_down, cp_enable,
	input wire logic [4*WORD_W-1:0] latch_words
);
	wire [2:0] sel = latch_words[3*WORD_W+3 +: 3];
	wire swpd = latch_words[3*WORD_W+2];
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_ce_low_off: assert property (!chip_en[*8] |-> power_down && !cp_enable)
		else $error("on with chip enable low");
	a_cp_on: assert property ((chip_en && !swpd)[*8] |-> cp_enable)
		else $error("pump off");
	a_swpd_off: assert property (swpd[*6] |-> !cp_enable) else $error("pump on");
	a_pd_cp_excl: assert property (power_down != cp_enable) else $error("power");
	a_latch_hold: assert property (!load_strobe[*8] |-> $stable(latch_words))
		else $error("latch moved");
	a_load_cause: assert property ($changed(latch_words) |-> $past(load_strobe, 3))
		else $error("latch without load");
	a_mon_route: assert property ((sel inside {[1:4]} && $stable(mon_src) && $stable(sel))[*6]
		|-> !monitor_output_oe_n && monitor_output_o == mon_src[3'h4-sel]) else $error("mon");
	a_mon_hiz: assert property ((!(sel inside {[1:4]}) && $stable(sel))[*6]
		|-> monitor_output_oe_n) else $error("mon driven");
	cover property (cp_enable);
	cover property (!monitor_output_oe_n);
	cover property ($rose(load_strobe));
endmodule
bind ssl_load_port ssl_load_port_checker #(.WORD_W(WORD_W)) u_chk (.*);

/* test/ssl_host.sv */
// host model that shifts words into the load port
`timescale 1ns/1ps
module ssl_host (
	output logic ser_clk,
	output logic ser_data,
	output logic load_strobe
);
	initial {ser_clk, ser_data, load_strobe} = 3'h0;
	// serial clock stands still between frames
	task automatic send(input logic [23:0] w, input logic ld);
		for (int i = 23; i >= 0; i--) begin
			ser_data = w[i];
			#6 ser_clk = 1;
			#6 ser_clk = 0;
		end
		ser_data = ~w[0];
		#6 load_strobe = ld;
		#30 load_strobe = 0;
		#20;
	endtask
endmodule

/* test/tb_ssl_load_port.sv */
// self-checking bench for the serial load port
`timescale 1ns/1ps
module tb_ssl_load_port;
	import ssl_pkg::*;
	typedef struct {logic [23:0] w; logic ce, pd, cp, oe, o;} ssl_row_t;
	logic clk = 0, arst_n = 1, chip_en = 1;
	ssl_mon_src_t mon_src = 4'b1010;
	wire ser_clk, ser_data, load_strobe, mo, oe_n, pd, cp;
	wire [95:0] lw;
	int mismatches = 0, checked = 0;
	ssl_row_t rows[7] = '{'{24'h12_3402, 1, 0, 1, 1, 0}, '{24'hfe_dc41, 1, 0, 1, 1, 0},
		'{24'h00_000b, 1, 0, 1, 0, 1}, '{24'h00_0013, 1, 0, 1, 0, 0},
		'{24'h00_001f, 1, 1, 0, 0, 1}, '{24'h00_0023, 0, 1, 0, 0, 0},
		'{24'h00_0033, 1, 0, 1, 1, 0}};
	ssl_load_port u_dut (.clk, .arst_n, .ser_clk, .ser_data, .load_strobe, .chip_en, .mon_src,
		.monitor_output_o(mo), .monitor_output_oe_n(oe_n), .power_down(pd), .cp_enable(cp),
		.latch_words(lw));
	ssl_host u_host (.ser_clk, .ser_data, .load_strobe);
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wrap_up;
		if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial forever #2 clk = ~clk;
	initial begin
		#20000 mismatches++;
		wrap_up;
	end
	initial begin
		// a real falling edge, so the strobe-domain flops leave unknown
		#1 arst_n = 0;
		repeat (6) @(posedge clk);
		#1 arst_n = 1;
		foreach (rows[i]) begin
			@(posedge clk) #1 chip_en = rows[i].ce;
			u_host.send(rows[i].w, 1);
			repeat (12) @(posedge clk);
			#1 chk(lw[rows[i].w[1:0]*24 +: 24], rows[i].w);
			chk(pd, rows[i].pd);
			chk(cp, rows[i].cp);
			chk(oe_n, rows[i].oe);
			if (!rows[i].oe) chk(mo, rows[i].o);
		end
		// shifting alone must leave the latches untouched
		u_host.send(24'h55_5502, 0);
		repeat (12) @(posedge clk);
		#1 chk(lw[48 +: 24], 24'h12_3402);
		arst_n = 0;
		repeat (2) @(posedge clk);
		#1 chk(pd, 1);
		chk(lw[72 +: 24], 24'h00_0000);
		// loads must work again after a mid-run reset
		@(posedge clk) #1 arst_n = 1;
		repeat (2) @(posedge clk);
		#1 chk(pd, 1);
		u_host.send(24'h00_0003, 1);
		repeat (12) @(posedge clk);
		#1 chk(lw[72 +: 24], 24'h00_0003);
		chk(pd, 0);
		chk(cp, 1);
		chk(oe_n, 1);
		wrap_up;
	end
endmodule
